// >>> hw/atf_edge_detect.sv
// rising edge detectors for all trigger sources
`timescale 1ns/1ns
module atf_edge_detect #(
    parameter int unsigned N = 9
) (
    input  wire logic         CLOCK,
    input  wire logic         RST,
    input  wire logic [N-1:0] level,
    output logic      [N-1:0] rise
);
    logic [N-1:0] prev;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_edge
            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    prev[i] <= 1'b0;
                end else begin
                    prev[i] <= level[i];
                end
            end
            // current sampled level against previous clock's level
            assign rise[i] = level[i] & ~prev[i];
        end
    endgenerate
endmodule

// >>> hw/atf_pkg.sv
// constants shared by the converter trigger and result-format block
package atf_pkg;
    localparam int unsigned RES_W = 10;

    // register byte offsets on the bus
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_CFG    = 5'h04;
    localparam logic [4:0] OFS_TRIG   = 5'h08;
    localparam logic [4:0] OFS_RESH   = 5'h0c;
    localparam logic [4:0] OFS_RESL   = 5'h10;
    localparam logic [4:0] OFS_SAMPLE = 5'h14;
    localparam logic [4:0] OFS_FLAGS  = 5'h18;

    // conversion_control fields
    localparam int unsigned CTRL_ON_BIT = 0;
    localparam int unsigned CTRL_GO_BIT = 1;
    localparam int unsigned CTRL_CH_LSB = 2;
    localparam logic [7:0]  CTRL_MASK   = 8'h7f;
    // conversion_config fields
    localparam int unsigned CFG_JUST_BIT = 7;
    localparam logic [7:0]  CFG_MASK     = 8'hf3;
    // trigger_select_control fields
    localparam int unsigned TRIG_LSB   = 4;
    localparam logic [7:0]  TRIG_MASK  = 8'hf0;
    localparam logic [7:0]  TRIG_RESET = 8'h00;
    // flags register bits
    localparam int unsigned FLG_DONE = 0;
    localparam int unsigned FLG_T0   = 1;
    localparam int unsigned FLG_T1   = 2;

    // trigger source codes
    localparam logic [3:0] SRC_NONE  = 4'h0;
    localparam logic [3:0] SRC_T0    = 4'h3;
    localparam logic [3:0] SRC_T1    = 4'h4;
    localparam logic [3:0] SRC_T2    = 4'h5;
    localparam logic [3:0] SRC_C1    = 4'h6;
    localparam logic [3:0] SRC_C2    = 4'h7;
    localparam logic [3:0] SRC_LC1   = 4'h8;
    localparam logic [3:0] SRC_LC4   = 4'hb;
    localparam int unsigned N_SRC    = 9;

    // conversion clock: one bit decision per this many device clocks
    localparam int unsigned BIT_DIV  = 4;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_RUN  = 2'b01,
        CV_LOAD = 2'b11
    } atf_conv_state_t;
endpackage

// >>> hw/atf_sar.sv
// successive-approximation sequencer; stops early on abort
`timescale 1ns/1ns
module atf_sar #(
    parameter int unsigned W = 10
) (
    input  wire logic         CLOCK,
    input  wire logic         RST,
    input  wire logic         start,
    input  wire logic         abort,
    input  wire logic         bit_tick,
    input  wire logic         cmp_in,
    output logic              busy,
    output logic              done,
    output logic      [W-1:0] value
);
    logic [W-1:0] acc;
    logic [W-1:0] probe;
    logic         last_bit;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            acc      <= '0;
            probe    <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
            value    <= '0;
            last_bit <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                acc      <= '0;
                probe    <= {1'b1, {(W-1){1'b0}}};
                busy     <= 1'b1;
                last_bit <= 1'b0;
            end else if (busy && abort) begin
                // unfinished bits copy the last decided bit
                for (int k = 0; k < W; k++) begin
                    value[k] <= probe[k] ? last_bit : acc[k];
                    if (probe[k]) begin
                        for (int j = 0; j < k; j++) begin
                            value[j] <= last_bit;
                        end
                    end
                end
                busy <= 1'b0;
                done <= 1'b1;
            end else if (busy && bit_tick) begin
                acc      <= acc | (cmp_in ? probe : '0);
                last_bit <= cmp_in;
                probe    <= probe >> 1;
                if (probe[0]) begin
                    value <= acc | (cmp_in ? probe : '0);
                    busy  <= 1'b0;
                    done  <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> hw/atf_top.sv
// converter control: auto trigger, sequencing, result format and bus slave
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
//
// Overview of operation
// - trigger source field in upper nibble, reset zero, lower nibble reads zero
// - code 0 none, 3..7 timers and comparators, 8..11 logic cells, rest reserved
// - only a rising edge of the selected source starts a conversion
// - timer0 and timer1 wrap events still set their own interrupt flags
// - left justified: result bits 9..2 fill the high byte
// - left justified: bits 1..0 in low byte bits 7..6, rest zero
// - right justified: bits 9..8 in high byte bits 1..0, rest zero
// - right justified: result bits 7..0 fill the low byte
// - qualifying trigger edge sets the in-progress flag like a software start
// - completion clears in-progress, sets done flag, loads result registers
// - six unused result bits forced to zero on every load
// - clearing in-progress early stores partial result, unfinished bits repeat last
module atf_top (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic      [1:0]  S_AXI_BRESP,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [31:0] S_AXI_ARADDR,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic      [31:0] S_AXI_RDATA,
    output logic      [1:0]  S_AXI_RRESP,
    input  wire logic        TIMER0_WRAP_EVENT,
    input  wire logic        TIMER1_WRAP_EVENT,
    input  wire logic        TIMER2_PERIOD_HIT,
    input  wire logic        COMPARATOR1_SYNCED_OUT,
    input  wire logic        COMPARATOR2_SYNCED_OUT,
    input  wire logic [3:0]  LOGIC_CELL_OUTPUT,
    input  wire logic        SAR_COMPARE,
    output logic             SAMPLE_HOLD,
    output logic      [4:0]  INPUT_CHANNEL_SELECT,
    output logic             CONVERTER_POWER_ON,
    output logic             CONVERSION_DONE_FLAG,
    output logic             TIMER0_FLAG,
    output logic             TIMER1_FLAG
);
    import atf_pkg::*;

    logic [7:0]         conversion_control;
    logic [7:0]         conversion_config;
    logic [7:0]         trigger_select_control;
    logic [7:0]         result_high_byte;
    logic [7:0]         result_low_byte;
    logic [2:0]         flags;
    logic               go;
    logic [N_SRC-1:0]   src_level;
    logic [N_SRC-1:0]   src_rise;
    logic [3:0]         trigger_source_select;
    logic               trig_start;
    logic               sar_busy;
    logic               sar_done;
    logic [RES_W-1:0]   conversion_result;
    logic               sw_go_set;
    logic               sw_go_clr;
    logic [1:0]         div_cnt;
    logic               bit_tick;
    logic               aw_held;
    logic               w_held;
    logic [4:0]         aw_addr;
    logic [7:0]         w_byte;
    logic               w_lane0;
    logic               do_write;
    logic [7:0]         rd_byte;
    logic               rd_hit;
    logic [4:0]         ar_addr;
    atf_conv_state_t    state;

    assign trigger_source_select = trigger_select_control[7:TRIG_LSB];
    assign src_level = {LOGIC_CELL_OUTPUT, COMPARATOR2_SYNCED_OUT, COMPARATOR1_SYNCED_OUT,
                        TIMER2_PERIOD_HIT, TIMER1_WRAP_EVENT, TIMER0_WRAP_EVENT};

    atf_edge_detect #(.N(N_SRC)) atf_edge_detect_i (
        .CLOCK (CLOCK),
        .RST   (RST),
        .level (src_level),
        .rise  (src_rise)
    );

    // decode: codes outside 3..11 select nothing
    always_comb begin
        trig_start = 1'b0;
        if (trigger_source_select >= SRC_T0 && trigger_source_select <= SRC_LC4) begin
            trig_start = src_rise[trigger_source_select - SRC_T0];
        end
    end

    // bit-decision clock enable
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= (div_cnt == 2'(BIT_DIV - 1)) ? 2'b00 : div_cnt + 2'b01;
        end
    end
    assign bit_tick = (div_cnt == 2'(BIT_DIV - 1));

    // bus write path: address and data accepted in either order
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
    assign do_write      = aw_held && w_held;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_byte       <= '0;
            w_lane0      <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR[4:0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held  <= 1'b1;
                w_byte  <= S_AXI_WDATA[7:0];
                w_lane0 <= S_AXI_WSTRB[0];
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_addr <= OFS_FLAGS && aw_addr[1:0] == 2'b00)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    assign sw_go_set = do_write && w_lane0 && aw_addr == OFS_CTRL && w_byte[CTRL_GO_BIT];
    assign sw_go_clr = do_write && w_lane0 && aw_addr == OFS_CTRL && !w_byte[CTRL_GO_BIT];

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            conversion_control     <= '0;
            conversion_config      <= '0;
            trigger_select_control <= TRIG_RESET;
        end else if (do_write && w_lane0) begin
            if (aw_addr == OFS_CTRL) begin
                conversion_control <= w_byte & CTRL_MASK;
            end else if (aw_addr == OFS_CFG) begin
                conversion_config <= w_byte & CFG_MASK;
            end else if (aw_addr == OFS_TRIG) begin
                trigger_select_control <= w_byte & TRIG_MASK;
            end
        end
    end

    // conversion-in-progress flag; a start that arrives while power is off is dropped
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            go    <= 1'b0;
            state <= CV_IDLE;
        end else begin
            case (state)
                CV_IDLE: begin
                    if (conversion_control[CTRL_ON_BIT] && (sw_go_set || trig_start)) begin
                        go    <= 1'b1;
                        state <= CV_RUN;
                    end
                end
                CV_RUN: begin
                    if (sw_go_clr) begin
                        go <= 1'b0;
                    end
                    if (sar_done) begin
                        state <= CV_LOAD;
                    end
                end
                CV_LOAD: begin
                    go    <= 1'b0;
                    state <= CV_IDLE;
                end
                default: begin
                    state <= CV_IDLE;
                end
            endcase
        end
    end

    // a finished run must not restart in the cycle its result is handed over
    atf_sar #(.W(RES_W)) atf_sar_i (
        .CLOCK    (CLOCK),
        .RST      (RST),
        .start    (state == CV_RUN && go && !sar_done),
        .abort    (sw_go_clr && state == CV_RUN),
        .bit_tick (bit_tick),
        .cmp_in   (SAR_COMPARE),
        .busy     (sar_busy),
        .done     (sar_done),
        .value    (conversion_result)
    );

    // result load; software may also write the result bytes directly
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            result_high_byte <= '0;
            result_low_byte  <= '0;
        end else if (state == CV_LOAD) begin
            if (conversion_config[CFG_JUST_BIT]) begin
                result_high_byte <= {6'h00, conversion_result[9:8]};
                result_low_byte  <= conversion_result[7:0];
            end else begin
                result_high_byte <= conversion_result[9:2];
                result_low_byte  <= {conversion_result[1:0], 6'h00};
            end
        end else if (do_write && w_lane0 && aw_addr == OFS_RESH) begin
            result_high_byte <= w_byte;
        end else if (do_write && w_lane0 && aw_addr == OFS_RESL) begin
            result_low_byte <= w_byte;
        end
    end

    // sticky flags: hardware set wins over a software clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            flags <= '0;
        end else begin
            if (do_write && w_lane0 && aw_addr == OFS_FLAGS) begin
                flags <= flags & ~w_byte[2:0];
            end
            if (state == CV_LOAD) begin
                flags[FLG_DONE] <= 1'b1;
            end
            if (src_rise[0]) begin
                flags[FLG_T0] <= 1'b1;
            end
            if (src_rise[1]) begin
                flags[FLG_T1] <= 1'b1;
            end
        end
    end

    // read mux
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (ar_addr == OFS_CTRL) begin
            rd_byte = {conversion_control[7:2], go, conversion_control[0]};
        end else if (ar_addr == OFS_CFG) begin
            rd_byte = conversion_config;
        end else if (ar_addr == OFS_TRIG) begin
            rd_byte = trigger_select_control;
        end else if (ar_addr == OFS_RESH) begin
            rd_byte = result_high_byte;
        end else if (ar_addr == OFS_RESL) begin
            rd_byte = result_low_byte;
        end else if (ar_addr == OFS_SAMPLE) begin
            rd_byte = {7'h00, sar_busy};
        end else if (ar_addr == OFS_FLAGS) begin
            rd_byte = {5'h00, flags};
        end else begin
            rd_hit = 1'b0;
        end
    end

    assign ar_addr       = S_AXI_ARADDR[4:0];
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= '0;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= {24'h000000, rd_byte};
            S_AXI_RRESP  <= (rd_hit && S_AXI_ARADDR[31:5] == '0) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // sampling stays closed while acquiring; acquisition length is software's job
    assign SAMPLE_HOLD          = sar_busy;
    assign INPUT_CHANNEL_SELECT = conversion_control[6:CTRL_CH_LSB];
    assign CONVERTER_POWER_ON   = conversion_control[CTRL_ON_BIT];
    assign CONVERSION_DONE_FLAG = flags[FLG_DONE];
    assign TIMER0_FLAG          = flags[FLG_T0];
    assign TIMER1_FLAG          = flags[FLG_T1];

    sequence s_load;
        state == CV_LOAD;
    endsequence

    AST_TRIG_STARTS: assert property (@(posedge CLOCK) disable iff (RST)
        (state == CV_IDLE && conversion_control[0] && trig_start) |=> go)
        else $error("trigger edge did not set in-progress");
    AST_NO_TRIG_RESERVED: assert property (@(posedge CLOCK) disable iff (RST)
        (trigger_source_select < SRC_T0 || trigger_source_select > SRC_LC4) |-> !trig_start)
        else $error("reserved code produced a start");
    AST_LEVEL_NO_START: assert property (@(posedge CLOCK) disable iff (RST)
        ($past(src_level) == src_level) |-> !trig_start)
        else $error("steady level produced a start");
    AST_DONE_CLEARS: assert property (@(posedge CLOCK) disable iff (RST)
        s_load |=> (!go && flags[FLG_DONE]))
        else $error("completion did not clear busy and set done");
    AST_RIGHT_JUST: assert property (@(posedge CLOCK) disable iff (RST)
        (s_load and conversion_config[7]) |=> (result_high_byte[7:2] == 6'h00 &&
        result_low_byte == $past(conversion_result[7:0])))
        else $error("right justified load wrong");
    AST_LEFT_JUST: assert property (@(posedge CLOCK) disable iff (RST)
        (s_load and !conversion_config[7]) |=> (result_low_byte[5:0] == 6'h00 &&
        result_high_byte == $past(conversion_result[9:2])))
        else $error("left justified load wrong");
    AST_T0_FLAG: assert property (@(posedge CLOCK) disable iff (RST)
        src_rise[0] |=> flags[FLG_T0])
        else $error("timer0 wrap flag not set");
    AST_TRIG_LOW: assert property (@(posedge CLOCK) disable iff (RST)
        trigger_select_control[3:0] == 4'h0)
        else $error("trigger low nibble not zero");
    AST_ABORT_ENDS: assert property (@(posedge CLOCK) disable iff (RST)
        (state == CV_RUN && sar_busy && sw_go_clr) |=> ##1 state == CV_LOAD)
        else $error("abort did not load partial result");
endmodule

// >>> testbench/atf_src_model.sv
// partner model: trigger sources and analog comparator decision
`timescale 1ns/1ns
module atf_src_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [8:0] fire,
    input  wire logic       cmp_bit,
    output logic      [8:0] level,
    output logic            cmp_out
);
    // sources are synchronous levels that may stay high for a long time,
    // so a level-sensitive start would show up as a repeated conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= 9'h000;
        end else begin
            level <= fire;
        end
    end
    // an analog decision is always present; it is not a released bus line
    assign cmp_out = cmp_bit;
endmodule

// >>> testbench/tb_atf_top.sv
// self-checking bench for the converter trigger and result-format block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_atf_top;
    import atf_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, hold, done_f, t0_f, t1_f, pwr;
    logic [4:0]  chan;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [8:0]  fire = 9'h000;
    logic [8:0]  level;
    logic        cmp_bit = 1'b0;
    logic        cmp_out;
    int          miscompares = 0;
    int          comparisons = 0;

    atf_top atf_top_i (.CLOCK(clock), .RST(rst),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .TIMER0_WRAP_EVENT(level[0]), .TIMER1_WRAP_EVENT(level[1]),
        .TIMER2_PERIOD_HIT(level[2]), .COMPARATOR1_SYNCED_OUT(level[3]),
        .COMPARATOR2_SYNCED_OUT(level[4]), .LOGIC_CELL_OUTPUT(level[8:5]),
        .SAR_COMPARE(cmp_out), .SAMPLE_HOLD(hold), .INPUT_CHANNEL_SELECT(chan),
        .CONVERTER_POWER_ON(pwr), .CONVERSION_DONE_FLAG(done_f),
        .TIMER0_FLAG(t0_f), .TIMER1_FLAG(t1_f));

    atf_src_model atf_src_model_i (.clk(clock), .rst(rst), .fire(fire),
        .cmp_bit(cmp_bit), .level(level), .cmp_out(cmp_out));

    always #20 clock = ~clock;

    task automatic conclude();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // requests stand until the rising edge that samples their ready high;
    // one idle edge between calls keeps a strobe from being set twice at once
    task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
        logic tb;
        int   n;
        n = 0;
        tb = 1'b0;
        r  = 2'b11;
        awvalid <= 1'b1;
        awaddr  <= {27'h0, a};
        wvalid  <= 1'b1;
        wdata   <= {24'h0, d};
        bready  <= 1'b1;
        while (!tb && n < 50) begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                tb = 1'b1;
                r  = bresp;
                bready <= 1'b0;
            end
            n++;
        end
        @(posedge clock);
        if (!tb) miscompares++;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic [1:0] r);
        logic tr;
        int   n;
        n = 0;
        tr = 1'b0;
        r  = 2'b11;
        arvalid <= 1'b1;
        araddr  <= {27'h0, a};
        rready  <= 1'b1;
        while (!tr && n < 50) begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                tr = 1'b1;
                d  = rdata[7:0];
                r  = rresp;
                rready <= 1'b0;
            end
            n++;
        end
        @(posedge clock);
        if (!tr) miscompares++;
    endtask

    task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK(nm, e, d)
    endtask

    task automatic watch(input int k, output logic s);
        s = 1'b0;
        repeat (k) begin
            @(negedge clock);
            if (hold === 1'b1) s = 1'b1;
        end
        @(posedge clock);
    endtask

    task automatic idle();
        int n;
        n = 0;
        @(negedge clock);
        while (hold !== 1'b0 && n < 120) begin
            @(negedge clock);
            n++;
        end
        `CHK("busy", 1'b0, hold)
        // the load cycle follows, and in-progress clears only after it
        repeat (2) @(posedge clock);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        logic [1:0] r;
        rc("trig_reset", OFS_TRIG, TRIG_RESET);
        wr(OFS_TRIG, 8'hff, r);
        `CHK("wr_okay", RESP_OKAY, r)
        rc("trig_mask", OFS_TRIG, 8'hf0);
        rd(5'h1c, d, r);
        `CHK("unmapped", RESP_SLVERR, r)
        wr(5'h1c, 8'h00, r);
        `CHK("wr_unmapped", RESP_SLVERR, r)
        wr(OFS_CTRL, 8'h01, r);
        wr(OFS_FLAGS, 8'h07, r);
    endtask

    // every code against every source; a held level must not restart
    task automatic t_trig();
        logic [1:0] r;
        logic       s, s2;
        for (int c = 0; c < 16; c++) begin
            wr(OFS_TRIG, 8'(c << 4), r);
            for (int i = 0; i < 9; i++) begin
                fire <= 9'(1 << i);
                watch(8, s);
                `CHK("start", (c == i + 3), s)
                if (s) idle();
                watch(10, s2);
                `CHK("restart", 1'b0, s2)
                fire <= 9'h000;
                if (i < 2) `CHK("tflag", 1'b1, (i == 0) ? t0_f : t1_f)
                wr(OFS_FLAGS, 8'h07, r);
            end
        end
    endtask

    // result registers are preloaded with the inverse so stale bits show
    task automatic t_fmt(input logic [7:0] cfg, input logic cb, input logic [7:0] eh,
                         input logic [7:0] el);
        logic [1:0] r;
        cmp_bit <= cb;
        wr(OFS_CFG, cfg, r);
        wr(OFS_RESH, ~eh, r);
        wr(OFS_RESL, ~el, r);
        wr(OFS_CTRL, 8'h29, r);
        `CHK("power", 1'b1, pwr)
        `CHK("channel", 5'h0a, chan)
        repeat (20) @(posedge clock); // acquisition wait after channel change
        wr(OFS_CTRL, 8'h2b, r);
        rc("in_progress", OFS_CTRL, 8'h2b);
        idle();
        rc("in_progress", OFS_CTRL, 8'h29);
        `CHK("done_flag", 1'b1, done_f)
        rc("res_high", OFS_RESH, eh);
        rc("res_low", OFS_RESL, el);
        wr(OFS_FLAGS, 8'h07, r);
    endtask

    task automatic t_abort();
        logic [1:0] r;
        cmp_bit <= 1'b1;
        wr(OFS_CTRL, 8'h2b, r);
        repeat (12) @(posedge clock);
        wr(OFS_CTRL, 8'h29, r);
        repeat (6) @(posedge clock);
        @(negedge clock);
        `CHK("aborted", 1'b0, hold)
        @(posedge clock);
        rc("part_low", OFS_RESL, 8'hff);
        rc("part_high", OFS_RESH, 8'h03);
    endtask

    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_regs();
        t_trig();
        t_fmt(8'h00, 1'b1, 8'hff, 8'hc0);
        t_fmt(8'h80, 1'b1, 8'h03, 8'hff);
        t_fmt(8'h00, 1'b0, 8'h00, 8'h00);
        t_fmt(8'h80, 1'b0, 8'h00, 8'h00);
        t_abort();
        conclude();
    end

    // the full sequence needs well under half of this span
    initial begin
        repeat (30000) @(posedge clock);
        miscompares++;
        conclude();
    end
endmodule
